// file: msd_pkg.sv
`default_nettype none
package msd_pkg;

	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned TICK_PERIOD_MS = 10;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int unsigned TICKS_PER_SEC  = 1000 / TICK_PERIOD_MS;

	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_DECEL     = 8'h04;
	localparam logic [7:0] REG_RESTART   = 8'h08;
	localparam logic [7:0] REG_VNOM      = 8'h0C;
	localparam logic [7:0] REG_VIMB      = 8'h10;
	localparam logic [7:0] REG_OVOLT     = 8'h14;
	localparam logic [7:0] REG_UVSTART   = 8'h18;
	localparam logic [7:0] REG_UVRUN     = 8'h1C;
	localparam logic [7:0] REG_CURR      = 8'h20;
	localparam logic [7:0] REG_FLC       = 8'h24;
	localparam logic [7:0] REG_STATUS    = 8'h28;
	localparam logic [7:0] REG_IRQ_STAT  = 8'h2C;
	localparam logic [7:0] REG_IRQ_MASK  = 8'h30;
	localparam int unsigned CFG_NUM      = 10;

	localparam int unsigned F_B0         = 0;
	localparam int unsigned F_B1         = 8;
	localparam int unsigned F_B2         = 16;
	localparam int unsigned F_B3         = 24;
	localparam int unsigned F_FAULT_RST  = 8;
	localparam int unsigned F_OUT_ON     = 16;
	localparam int unsigned F_RST_BLOCK  = 17;
	localparam int unsigned F_MODE       = 18;

	localparam logic [0:CFG_NUM-1][31:0] CFG_MASK = '{
		32'h0000_0003, 32'h003F_7F7F, 32'h0000_03FF, 32'h0000_03FF, 32'h0000_1F1F,
		32'h0000_1F0F, 32'h0000_FF1F, 32'h0000_1F1F, 32'h1F1F_0F0F, 32'h0000_FFFF};
	localparam logic [0:CFG_NUM-1][31:0] CFG_RESET = '{
		32'h0000_0000, 32'h000A_1E3C, 32'h0000_0000, 32'h0000_01E0, 32'h0000_0A00,
		32'h0000_0A00, 32'h0000_0A00, 32'h0000_0200, 32'h0200_0101, 32'h0000_0064};

	localparam logic [1:0] DECEL_OFF  = 2'h0;
	localparam logic [1:0] DECEL_KEEP = 2'h2;
	localparam logic [6:0] PCT_FULL   = 7'h64;

	localparam int unsigned C_VIMB = 0;
	localparam int unsigned C_OV   = 1;
	localparam int unsigned C_UVS  = 2;
	localparam int unsigned C_UVR  = 3;
	localparam int unsigned C_SHRT = 4;
	localparam int unsigned C_SHNT = 5;
	localparam int unsigned C_CIMB = 6;
	localparam int unsigned C_OVLD = 7;
	localparam int unsigned N_TIMED = 7;

	typedef enum logic [1:0] {
		MSD_IDLE,
		MSD_RUN,
		MSD_DECEL
	} msd_mode_t;

endpackage
`default_nettype wire

// file: msd_tick.sv
`timescale 1ns/100ps
`default_nettype none
module msd_tick #(
	parameter int unsigned CYCLES = 2_000_000
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} msd_tick_st_t;

	msd_tick_st_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == 32'(CYCLES - 1)) begin
			s_nxt.cnt = 32'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick_o = s_r.tick;
endmodule // msd_tick
`default_nettype wire

// file: msd_persist.sv
`timescale 1ns/100ps
`default_nettype none
module msd_persist #(
	parameter int unsigned DW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          sec_tick_i,
	input  wire logic          enable_i,
	input  wire logic          cond_i,
	input  wire logic [DW-1:0] delay_i,
	output logic               fire_o
);
	typedef struct packed {
		logic [DW:0] cnt;
		logic        fire;
	} msd_persist_st_t;

	msd_persist_st_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!(enable_i && cond_i)) begin
			s_nxt.cnt = '0;
		end else if (sec_tick_i && s_r.cnt <= {1'b0, delay_i}) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
		// Trips once the condition has outlasted the delay, not merely reached it
		s_nxt.fire = enable_i && cond_i && (s_r.cnt > {1'b0, delay_i});
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign fire_o = s_r.fire;
endmodule // msd_persist
`default_nettype wire

// file: msd_top.sv
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Decel select: 0 off, 1 soft-stop with overload shutoff, 2 keep ramping.
// - Stop with soft-stop steps output at once to start level, default 60%.
// - Output turns off at shut-off level, default 30%, kept below start level.
// - Ramp from start to shut-off level takes ramp time, 1-60 s, default 10.
// - Power loss blocks restart for 1-999 s; zero means no delay.
// - Nominal line voltage 200-600 V, default 480, is the voltage reference.
// - Voltage imbalance: any line voltage off average by at least set percent.
// - Voltage imbalance trips after lasting longer than 1-20 s, default 10.
// - Over-voltage beyond nominal plus percent trips after delay, default 10 s.
// - While starting, voltage below nominal minus percent trips after delay.
// - At speed, voltage at or below nominal minus percent trips after delay.
// - Among overlapping voltage trips, lowest threshold and fastest delay acts first.
// - Current thresholds are percentages of programmed full-load current.
// - Shorted thyristor trips after 1-10 s delay, default 1; zero disables.
// - Current flowing while off trips after 1-10 s delay; zero disables.
// - Current imbalance at or above 5-30 percent trips after delay, default 2 s.
module msd_top
	import msd_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES,
	parameter int unsigned AW       = 8
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	output logic [31:0]        dat_o,
	output logic               ack_o,
	input  wire logic          start_cmd_i,
	input  wire logic          stop_cmd_i,
	input  wire logic          at_speed_i,
	input  wire logic          overload_trip_i,
	input  wire logic          power_lost_i,
	input  wire logic          thyristor_short_i,
	input  wire logic [9:0]    v_ab_i,
	input  wire logic [9:0]    v_bc_i,
	input  wire logic [9:0]    v_ca_i,
	input  wire logic [15:0]   i_a_i,
	input  wire logic [15:0]   i_b_i,
	input  wire logic [15:0]   i_c_i,
	output logic               output_on_o,
	output logic [6:0]         output_level_o,
	output logic               restart_block_o,
	output logic               fault_o,
	output logic [7:0]         fault_cause_o,
	output logic               irq_o
);
	typedef struct packed {
		logic [0:CFG_NUM-1][31:0] cfg;
		msd_mode_t                mode;
		logic [6:0]               level;
		logic [12:0]              acc;
		logic [6:0]               sub;
		logic                     sec;
		logic [9:0]               restart_cnt;
		logic [7:0]               cause;
		logic [7:0]               irq_stat;
		logic [7:0]               irq_mask;
		logic                     ack;
		logic [31:0]              rdata;
	} msd_st_t;

	msd_st_t s_r, s_nxt;

	logic                centi_tick;
	logic [N_TIMED-1:0]  cond;
	logic [N_TIMED-1:0]  enable;
	logic [N_TIMED-1:0]  fire;
	logic [7:0]          delay [N_TIMED];

	msd_tick #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (centi_tick)
	);

	genvar g;
	generate
		for (g = 0; g < N_TIMED; g++) begin : g_persist
			msd_persist #(
				.DW (8)
			) u_persist (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.sec_tick_i (s_r.sec),
				.enable_i   (enable[g]),
				.cond_i     (cond[g]),
				.delay_i    (delay[g]),
				.fire_o     (fire[g])
			);
		end
	endgenerate

	// Configuration fields
	logic [1:0]  decel_select;
	logic [6:0]  decel_start_pct;
	logic [6:0]  decel_shutoff_level;
	logic [5:0]  decel_ramp_time;
	logic [9:0]  restart_delay_time;
	logic [9:0]  nominal_line_voltage;
	logic [4:0]  volt_imbalance_thresh;
	logic [3:0]  over_volt_thresh;
	logic [4:0]  under_volt_start_thresh;
	logic [4:0]  under_volt_run_thresh;
	logic [4:0]  curr_imbalance_thresh;
	logic [15:0] motor_full_load_current;

	assign decel_select            = s_r.cfg[0][F_B0+:2];
	assign decel_start_pct         = s_r.cfg[1][F_B0+:7];
	assign decel_shutoff_level     = s_r.cfg[1][F_B1+:7];
	assign decel_ramp_time         = s_r.cfg[1][F_B2+:6];
	assign restart_delay_time      = s_r.cfg[2][F_B0+:10];
	assign nominal_line_voltage    = s_r.cfg[3][F_B0+:10];
	assign volt_imbalance_thresh   = s_r.cfg[4][F_B0+:5];
	assign over_volt_thresh        = s_r.cfg[5][F_B0+:4];
	assign under_volt_start_thresh = s_r.cfg[6][F_B0+:5];
	assign under_volt_run_thresh   = s_r.cfg[7][F_B0+:5];
	assign curr_imbalance_thresh   = s_r.cfg[8][F_B2+:5];
	assign motor_full_load_current = s_r.cfg[9][F_B0+:16];

	assign delay[C_VIMB] = {3'h0, s_r.cfg[4][F_B1+:5]};
	assign delay[C_OV]   = {3'h0, s_r.cfg[5][F_B1+:5]};
	assign delay[C_UVS]  = s_r.cfg[6][F_B1+:8];
	assign delay[C_UVR]  = {3'h0, s_r.cfg[7][F_B1+:5]};
	assign delay[C_SHRT] = {4'h0, s_r.cfg[8][F_B0+:4]};
	assign delay[C_SHNT] = {4'h0, s_r.cfg[8][F_B1+:4]};
	assign delay[C_CIMB] = {3'h0, s_r.cfg[8][F_B3+:5]};

	// Zero thresholds disable their trips; zero delays disable only shorted thyristor and shunt
	assign enable[C_VIMB] = volt_imbalance_thresh != 5'h0;
	assign enable[C_OV]   = over_volt_thresh != 4'h0;
	assign enable[C_UVS]  = under_volt_start_thresh != 5'h0;
	assign enable[C_UVR]  = under_volt_run_thresh != 5'h0;
	assign enable[C_SHRT] = delay[C_SHRT] != 8'h0;
	assign enable[C_SHNT] = delay[C_SHNT] != 8'h0;
	assign enable[C_CIMB] = curr_imbalance_thresh != 5'h0;

	// Shut-off level forced at least one percent under start level
	logic [6:0] shut_eff;
	assign shut_eff = (decel_shutoff_level < decel_start_pct) ? decel_shutoff_level :
		((decel_start_pct == 7'h0) ? 7'h0 : decel_start_pct - 7'h1);

	// Percentage comparisons, cross-multiplied to avoid division
	always_comb begin
		logic [9:0]  v [3];
		logic [15:0] i [3];
		logic [11:0] vsum;
		logic [11:0] dev;
		logic [15:0] idiff;
		logic [19:0] v100;
		logic [19:0] ov_lim;
		logic [19:0] uvs_lim;
		logic [19:0] uvr_lim;
		logic [19:0] vimb_lim;
		logic [23:0] cimb_lim;
		v = '{v_ab_i, v_bc_i, v_ca_i};
		i = '{i_a_i, i_b_i, i_c_i};
		vsum = 12'(v[0]) + 12'(v[1]) + 12'(v[2]);
		dev = 12'h0;
		idiff = 16'h0;
		v100 = 20'h0;
		ov_lim = 20'(nominal_line_voltage) * 20'(7'(PCT_FULL) + 7'(over_volt_thresh));
		uvs_lim = 20'(nominal_line_voltage) * 20'(PCT_FULL - 7'(under_volt_start_thresh));
		uvr_lim = 20'(nominal_line_voltage) * 20'(PCT_FULL - 7'(under_volt_run_thresh));
		vimb_lim = 20'(volt_imbalance_thresh) * 20'(vsum);
		cimb_lim = 24'(curr_imbalance_thresh) * 24'(motor_full_load_current);
		cond = '0;
		for (int k = 0; k < 3; k++) begin
			v100 = 20'(v[k]) * 20'(PCT_FULL);
			dev = (12'(v[k]) * 12'h3 > vsum) ? 12'(v[k]) * 12'h3 - vsum : vsum - 12'(v[k]) * 12'h3;
			if (20'(dev) * 20'(PCT_FULL) >= vimb_lim)
				cond[C_VIMB] = 1'b1;
			if (v100 > ov_lim)
				cond[C_OV] = 1'b1;
			if (v100 < uvs_lim && s_r.mode == MSD_RUN && !at_speed_i)
				cond[C_UVS] = 1'b1;
			if (v100 <= uvr_lim && s_r.mode == MSD_RUN && at_speed_i)
				cond[C_UVR] = 1'b1;
			idiff = (i[k] > i[(k + 1) % 3]) ? i[k] - i[(k + 1) % 3] : i[(k + 1) % 3] - i[k];
			if (24'(idiff) * 24'(PCT_FULL) >= cimb_lim)
				cond[C_CIMB] = 1'b1;
			if (i[k] != 16'h0 && s_r.mode == MSD_IDLE)
				cond[C_SHNT] = 1'b1;
		end
		cond[C_SHRT] = thyristor_short_i;
	end

	// Bus decode
	logic [5:0]  widx;
	logic [31:0] bmask;
	logic [31:0] rd_mux;
	logic        wr_en;
	logic        fault_rst;
	assign widx = adr_i[7:2];
	assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	// Writes land on the edge where the master sees ack
	assign wr_en = cyc_i && stb_i && we_i && s_r.ack;
	assign fault_rst = wr_en && {widx, 2'b00} == REG_CTRL && sel_i[1] && dat_i[F_FAULT_RST];

	always_comb begin
		rd_mux = 32'h0;
		if (widx < 6'(CFG_NUM))
			rd_mux = s_r.cfg[widx[3:0]];
		else if ({widx, 2'b00} == REG_STATUS)
			rd_mux = {12'h0, s_r.mode, s_r.restart_cnt != 10'h0, s_r.mode != MSD_IDLE,
				1'b0, s_r.level, s_r.cause};
		else if ({widx, 2'b00} == REG_IRQ_STAT)
			rd_mux = {24'h0, s_r.irq_stat};
		else if ({widx, 2'b00} == REG_IRQ_MASK)
			rd_mux = {24'h0, s_r.irq_mask};
	end

	logic [7:0] new_cause;
	logic       ovld_off;
	logic [12:0] ramp_span;
	logic [12:0] acc_sum;

	// Overload cuts output except when decel is told to ride through it
	assign ovld_off = overload_trip_i && s_r.mode != MSD_IDLE &&
		!(s_r.mode == MSD_DECEL && decel_select == DECEL_KEEP);
	assign new_cause = {ovld_off, fire};
	assign ramp_span = 13'(decel_ramp_time) * 13'(PCT_FULL);
	assign acc_sum = s_r.acc + 13'(decel_start_pct - shut_eff);

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = cyc_i && stb_i && !s_r.ack;
		s_nxt.rdata = rd_mux;
		if (wr_en) begin
			for (int k = 0; k < CFG_NUM; k++) begin
				if (widx == 6'(k))
					s_nxt.cfg[k] = ((s_r.cfg[k] & ~bmask) | (dat_i & bmask)) & CFG_MASK[k];
			end
			if ({widx, 2'b00} == REG_IRQ_MASK && sel_i[0])
				s_nxt.irq_mask = dat_i[7:0];
		end

		// Seconds time base from the hundredth tick
		s_nxt.sec = 1'b0;
		if (centi_tick) begin
			if (s_r.sub == 7'(TICKS_PER_SEC - 1)) begin
				s_nxt.sub = 7'h0;
				s_nxt.sec = 1'b1;
			end else begin
				s_nxt.sub = s_r.sub + 7'h1;
			end
		end

		if (power_lost_i)
			s_nxt.restart_cnt = restart_delay_time;
		else if (s_r.sec && s_r.restart_cnt != 10'h0)
			s_nxt.restart_cnt = s_r.restart_cnt - 10'h1;

		unique case (s_r.mode)
			MSD_IDLE: begin
				s_nxt.level = 7'h0;
				s_nxt.acc = 13'h0;
				if (start_cmd_i && !stop_cmd_i && s_r.cause == 8'h0 &&
					s_r.restart_cnt == 10'h0 && !power_lost_i) begin
					s_nxt.mode = MSD_RUN;
					s_nxt.level = PCT_FULL;
				end
			end
			MSD_RUN: begin
				if (stop_cmd_i) begin
					if (decel_select != DECEL_OFF && decel_start_pct != 7'h0) begin
						s_nxt.mode = MSD_DECEL;
						s_nxt.level = decel_start_pct;
						s_nxt.acc = 13'h0;
					end else begin
						s_nxt.mode = MSD_IDLE;
						s_nxt.level = 7'h0;
					end
				end
			end
			MSD_DECEL: begin
				// Slope is span over ramp time, one percent per step
				if (centi_tick) begin
					if (acc_sum >= ramp_span) begin
						s_nxt.acc = acc_sum - ramp_span;
						s_nxt.level = s_r.level - 7'h1;
					end else begin
						s_nxt.acc = acc_sum;
					end
				end
				if (s_r.level <= shut_eff) begin
					s_nxt.mode = MSD_IDLE;
					s_nxt.level = 7'h0;
				end
			end
		endcase

		// First timer to expire wins, so the tightest setting acts first
		if (new_cause != 8'h0 || power_lost_i) begin
			s_nxt.mode = MSD_IDLE;
			s_nxt.level = 7'h0;
		end
		s_nxt.cause = (fault_rst ? 8'h0 : s_r.cause) | new_cause;

		// Sticky event bits; a new event beats a same-cycle clear
		s_nxt.irq_stat = s_r.irq_stat;
		if (wr_en && {widx, 2'b00} == REG_IRQ_STAT && sel_i[0])
			s_nxt.irq_stat = s_r.irq_stat & ~dat_i[7:0];
		s_nxt.irq_stat = s_nxt.irq_stat | new_cause;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.cfg <= CFG_RESET;
			s_r.mode <= MSD_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dat_o           = s_r.rdata;
	assign ack_o           = s_r.ack;
	assign output_on_o     = s_r.mode != MSD_IDLE;
	assign output_level_o  = s_r.level;
	assign restart_block_o = s_r.restart_cnt != 10'h0;
	assign fault_o         = s_r.cause != 8'h0;
	assign fault_cause_o   = s_r.cause;
	assign irq_o           = (s_r.irq_stat & s_r.irq_mask) != 8'h0;
endmodule // msd_top
`default_nettype wire

// file: msd_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module msd_top_sva
	import msd_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       we_i,
	input wire logic       ack_o,
	input wire logic       stop_cmd_i,
	input wire logic       power_lost_i,
	input wire logic       output_on_o,
	input wire logic [6:0] output_level_o,
	input wire logic       restart_block_o,
	input wire logic       fault_o,
	input wire logic [7:0] fault_cause_o
);
	// Any write may carry a fault reset, so latch checks skip those cycles
	wire logic bus_wr = cyc_i && stb_i && we_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence bus_start_s;
		$rose(cyc_i && stb_i);
	endsequence
	sequence run_stop_s;
		output_on_o && output_level_o == PCT_FULL && stop_cmd_i;
	endsequence
	sequence ramping_s;
		output_on_o && output_level_o < PCT_FULL;
	endsequence
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (bus_start_s |=> ack_o)
		else $error("no ack one cycle after request");
	trip_off_a: assert property ($rose(fault_o) |-> ##[0:1] !output_on_o)
		else $error("output still on after trip");
	fault_hold_a: assert property (fault_o && !bus_wr |=> fault_o)
		else $error("fault dropped without reset");
	cause_keep_a: assert property (!bus_wr |=> (fault_cause_o & $past(fault_cause_o)) == $past(fault_cause_o))
		else $error("latched cause bit lost");
	stop_step_a: assert property (run_stop_s |=> output_level_o < PCT_FULL)
		else $error("no step down on stop");
	ramp_step_a: assert property (ramping_s |=> !output_on_o || (output_level_o <= $past(output_level_o) && output_level_o + 7'h01 >= $past(output_level_o)))
		else $error("ramp step not one percent down");
	idle_level_a: assert property (!output_on_o |-> output_level_o == 7'h00)
		else $error("level nonzero while off");
	power_loss_a: assert property (power_lost_i |=> !output_on_o)
		else $error("output on after power loss");
	block_start_a: assert property (restart_block_o && !output_on_o |=> !output_on_o)
		else $error("start during restart block");
	fault_start_a: assert property (fault_o && !output_on_o && !bus_wr |=> !output_on_o)
		else $error("start with fault latched");
endmodule // msd_top_sva
bind msd_top msd_top_sva sva_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .ack_o(ack_o), .stop_cmd_i(stop_cmd_i), .power_lost_i(power_lost_i),
	.output_on_o(output_on_o), .output_level_o(output_level_o),
	.restart_block_o(restart_block_o), .fault_o(fault_o), .fault_cause_o(fault_cause_o));
`default_nettype wire

// file: motor_decel_and_line_protection_tb.sv
`timescale 1ns/100ps
`default_nettype none
module motor_decel_and_line_protection_tb import msd_pkg::*;;
	localparam int S = 2000;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, start_cmd_i, stop_cmd_i;
	logic        at_speed_i, overload_trip_i, power_lost_i, thyristor_short_i;
	logic        output_on_o, restart_block_o, fault_o, irq_o;
	logic [7:0]  adr_i, fault_cause_o;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q, d;
	logic [9:0]  v_ab_i, v_bc_i, v_ca_i;
	logic [15:0] i_a_i, i_b_i, i_c_i;
	logic [6:0]  output_level_o, lv;
	int          errors, check_count, n;
	msd_top #(.TICK_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.start_cmd_i(start_cmd_i), .stop_cmd_i(stop_cmd_i), .at_speed_i(at_speed_i),
		.overload_trip_i(overload_trip_i), .power_lost_i(power_lost_i),
		.thyristor_short_i(thyristor_short_i), .v_ab_i(v_ab_i), .v_bc_i(v_bc_i), .v_ca_i(v_ca_i),
		.i_a_i(i_a_i), .i_b_i(i_b_i), .i_c_i(i_c_i), .output_on_o(output_on_o),
		.output_level_o(output_level_o), .restart_block_o(restart_block_o), .fault_o(fault_o),
		.fault_cause_o(fault_cause_o), .irq_o(irq_o));
	task automatic close_out();
		if (errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic hold(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s);
		int k;
		k = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= dw;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'h1 && k < 20);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		if (k >= 20) begin
			errors++;
			close_out();
		end
		@(posedge clk_i);
	endtask
	// Waits for a trip (sel 0) or for the restart block to lift (sel 1)
	task automatic wait_for(input int sel, input int lim);
		n = 0;
		while ((sel == 0 ? fault_o : !restart_block_o) !== 1'h1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim) begin
			errors++;
			close_out();
		end
	endtask
	task automatic cmd(input logic stop);
		stop_cmd_i  <= stop;
		start_cmd_i <= !stop;
		@(posedge clk_i);
		stop_cmd_i  <= 1'h0;
		start_cmd_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic ramp_out();
		n = 0;
		while (output_on_o === 1'h1 && n < 3 * S) begin
			lv = output_level_o;
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic clear_fault();
		wb(1'h1, REG_CTRL, 32'h0000_0101, 4'h3);
		chk(fault_o, 1'h0);
	endtask
	// Random line voltage strictly above nominal plus margin
	function automatic logic [9:0] over(input int vn, input int t);
		return 10'(vn * (100 + t) / 100 + 1 + $urandom % 40);
	endfunction
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, start_cmd_i, stop_cmd_i} = 6'h20;
		{at_speed_i, overload_trip_i, power_lost_i, thyristor_short_i} = 4'h0;
		{adr_i, sel_i, dat_i} = 44'h0;
		{v_ab_i, v_bc_i, v_ca_i} = {3{10'h1E0}};
		{i_a_i, i_b_i, i_c_i} = 48'h0;
		errors = 0;
		check_count = 0;
		n = $urandom(11);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (int i = 0; i < CFG_NUM; i++) begin
			wb(1'h0, 8'(i * 4), 32'h0, 4'hF);
			chk(q, CFG_RESET[i]);
		end
		wb(1'h1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
		wb(1'h0, 8'h3C, 32'h0, 4'hF);
		chk(q, 32'h0);
		wb(1'h1, REG_DECEL, 32'h0001_1E3C, 4'hF);
		wb(1'h1, REG_CTRL, 32'h0000_0001, 4'hF);
		cmd(1'h0);
		chk({output_on_o, output_level_o}, {1'h1, PCT_FULL});
		cmd(1'h1);
		chk(output_level_o, 7'h3C);
		ramp_out();
		chk(lv, 7'h1E);
		chk(n > 9 * S / 10 && n < 11 * S / 10, 1'h1);
		cmd(1'h0);
		cmd(1'h1);
		overload_trip_i <= 1'h1;
		hold(3);
		chk(output_on_o, 1'h0);
		chk(fault_cause_o[7], 1'h1);
		overload_trip_i <= 1'h0;
		clear_fault();
		wb(1'h1, REG_CTRL, 32'h0000_0002, 4'hF);
		cmd(1'h0);
		cmd(1'h1);
		overload_trip_i <= 1'h1;
		hold(3);
		chk(output_on_o, 1'h1);
		overload_trip_i <= 1'h0;
		ramp_out();
		wb(1'h1, REG_CTRL, 32'h0000_0000, 4'hF);
		cmd(1'h0);
		cmd(1'h1);
		chk(output_on_o, 1'h0);
		wb(1'h1, REG_OVOLT, 32'h0000_0205, 4'hF);
		cmd(1'h0);
		v_ab_i <= over(480, 5);
		hold(19 * S / 10);
		chk(fault_o, 1'h0);
		v_ab_i <= 10'h1F8;
		hold(4);
		v_ab_i <= over(480, 5);
		hold(19 * S / 10);
		chk(fault_o, 1'h0);
		wait_for(0, 12 * S / 10);
		chk(fault_cause_o, 8'h02);
		v_ab_i <= 10'h1E0;
		hold(2);
		chk(output_on_o, 1'h0);
		wb(1'h1, REG_OVOLT, 32'h0, 4'hF);
		chk(irq_o, 1'h0);
		wb(1'h1, REG_IRQ_MASK, 32'h0000_00FF, 4'h1);
		hold(2);
		chk(irq_o, 1'h1);
		wb(1'h1, REG_IRQ_STAT, 32'h0000_0082, 4'h1);
		hold(2);
		chk(irq_o, 1'h0);
		clear_fault();
		i_b_i <= 16'(1 + $urandom % 500);
		hold(9 * S / 10);
		chk(fault_o, 1'h0);
		wait_for(0, 13 * S / 10);
		chk(fault_cause_o, 8'h20);
		cmd(1'h0);
		chk(output_on_o, 1'h0);
		i_b_i <= 16'h0;
		clear_fault();
		wb(1'h1, REG_RESTART, 32'h0000_0002, 4'hF);
		power_lost_i <= 1'h1;
		hold(1);
		power_lost_i <= 1'h0;
		hold(2);
		cmd(1'h0);
		chk({restart_block_o, output_on_o}, 2'h2);
		hold(9 * S / 10);
		chk(restart_block_o, 1'h1);
		wait_for(1, 13 * S / 10);
		cmd(1'h0);
		chk(output_on_o, 1'h1);
		wb(1'h0, REG_STATUS, 32'h0, 4'hF);
		chk(q, 32'h0005_6400);
		thyristor_short_i <= 1'h1;
		wait_for(0, 25 * S / 10);
		chk(fault_cause_o, 8'h10);
		chk(output_on_o, 1'h0);
		thyristor_short_i <= 1'h0;
		hold(2);
		clear_fault();
		wb(1'h1, REG_UVRUN, 32'h0000_010A, 4'hF);
		cmd(1'h0);
		at_speed_i <= 1'h1;
		// Exactly nominal minus ten percent, the inclusive edge
		v_bc_i <= 10'h1B0;
		wait_for(0, 25 * S / 10);
		chk(fault_cause_o, 8'h08);
		at_speed_i <= 1'h0;
		v_bc_i <= 10'h1E0;
		hold(2);
		clear_fault();
		for (int i = 2; i < CFG_NUM; i++) begin
			d = $urandom;
			wb(1'h1, 8'(i * 4), d, 4'hF);
			wb(1'h0, 8'(i * 4), 32'h0, 4'hF);
			chk(q, d & CFG_MASK[i]);
		end
		close_out();
	end
endmodule // motor_decel_and_line_protection_tb
`default_nettype wire
